// file: rtl/asr_receiver.sv
// asynchronous serial receive path with character fifo and pin control
//
// Notes on behaviour
// - port enable makes receive pin input
// - port enable drives transmit pin, latch disconnected
// - falling edge starts character, start is zero
// - wait half bit, recheck start low
// - high at mid start: silent abort
// - full bit period to each centre
// - majority vote decides each data bit
// - low stop bit sets frame error
// - completed character pushed, pending flag set
// - read returns and removes oldest character
// - after overrun, no reception until cleared
// - pending flag while enabled and unread
// - frame error follows oldest unread character
// - port disable clears; receive disable keeps characters, clears overrun
// - frame error alone raises no request
module asr_receiver #(
    parameter int DATA_BITS = asr_pkg::DATA_BITS,
    parameter int FIFO_DEPTH = asr_pkg::FIFO_DEPTH,
    parameter int BAUD_DIV = asr_pkg::BAUD_DIV
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SERIAL_PORT_ENABLE,
    input wire logic CONTINUOUS_RECEIVE_ENABLE,
    input wire logic RECEIVE_LINE_PIN_IN,
    input wire logic RECEIVE_PIN_DIRECTION_BIT,
    input wire logic RECEIVE_PORT_LATCH,
    input wire logic TRANSMIT_PIN_DIRECTION_BIT,
    input wire logic TRANSMIT_PORT_LATCH,
    input wire logic TRANSMIT_SERIAL_DATA,
    input wire logic RECEIVE_HOLDING_READ,
    output logic [DATA_BITS-1:0] RECEIVE_HOLDING_DATA,
    output logic RECEIVE_PENDING_FLAG,
    output logic FRAME_ERROR_STATUS,
    output logic OVERRUN_STATUS,
    output logic RECEIVE_BUSY,
    output logic RECEIVE_LINE_PIN_OUT,
    output logic RECEIVE_LINE_PIN_OE_N,
    output logic TRANSMIT_LINE_PIN_OUT,
    output logic TRANSMIT_LINE_PIN_OE_N
);

    localparam int TW = asr_pkg::TICK_W;
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int BW = $clog2(DATA_BITS + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(FIFO_DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [BW-1:0] BIT_LAST = BW'(DATA_BITS - 1);

    typedef struct packed {
        asr_pkg::asr_state_type state;
        logic [TW-1:0] tick_cnt;
        logic [BW-1:0] bit_cnt;
        logic [DATA_BITS-1:0] shift;
        logic [1:0] votes;
        logic line_prev;
        logic [FIFO_DEPTH-1:0][DATA_BITS-1:0] mem;
        logic [FIFO_DEPTH-1:0] frame_error_status_mem;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] wr_ptr;
        logic [CW-1:0] count;
        logic overrun;
        logic [DATA_BITS-1:0] data_out;
        logic pending;
        logic frame_error_status_out;
        logic busy;
        logic rx_out;
        logic rx_oe_n;
        logic tx_out;
        logic tx_oe_n;
    } asr_regs_type;

    asr_regs_type r;
    asr_regs_type n;
    logic tick;

    // ==========================================================
    // helpers
    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        ptr_next = (p == PTR_LAST) ? '0 : p + PW'(1);
    endfunction

    // two of three samples win, so a single glitch near the centre is ignored
    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    // ==========================================================
    // bit timing reference
    asr_baud_tick #(
        .DIV(BAUD_DIV)
    ) u_baud (
        .CLK(CLK),
        .RST_N(RST_N),
        .enable(SERIAL_PORT_ENABLE),
        .tick(tick)
    );

    // ==========================================================
    // next state of the whole receive path
    always_comb begin
        logic rx_run;
        logic pop;
        logic push;
        logic voted;
        logic [TW-1:0] cnt_inc;
        rx_run = SERIAL_PORT_ENABLE & CONTINUOUS_RECEIVE_ENABLE & ~r.overrun;
        pop = 1'b0;
        push = 1'b0;
        voted = majority(r.votes[0], r.votes[1], RECEIVE_LINE_PIN_IN);
        cnt_inc = r.tick_cnt + TW'(1);
        n = r;
        n.line_prev = RECEIVE_LINE_PIN_IN;

        // reading removes the oldest character; a read on empty does nothing
        if (RECEIVE_HOLDING_READ && r.count != '0) begin
            pop = 1'b1;
            n.rd_ptr = ptr_next(r.rd_ptr);
        end

        // receive sequencer; the start edge is taken on any clock, later steps only on oversample ticks
        unique case (r.state)
            asr_pkg::ASR_IDLE: begin
                n.tick_cnt = asr_pkg::TICK_ZERO;
                if (rx_run && r.line_prev == asr_pkg::LINE_IDLE &&
                    RECEIVE_LINE_PIN_IN == asr_pkg::START_LEVEL) begin
                    n.state = asr_pkg::ASR_START;
                end
            end
            asr_pkg::ASR_START: begin
                if (tick) begin
                    n.tick_cnt = cnt_inc;
                    if (cnt_inc == asr_pkg::HALF_BIT_TICKS) begin
                        n.tick_cnt = asr_pkg::TICK_ZERO;
                        n.bit_cnt = '0;
                        // a high level here was noise: back to edge search, no flag
                        n.state = (RECEIVE_LINE_PIN_IN == asr_pkg::START_LEVEL) ?
                            asr_pkg::ASR_DATA : asr_pkg::ASR_IDLE;
                    end
                end
            end
            asr_pkg::ASR_DATA: begin
                if (tick) begin
                    n.tick_cnt = cnt_inc;
                    if (cnt_inc == asr_pkg::VOTE_FIRST_TICK) begin
                        n.votes[0] = RECEIVE_LINE_PIN_IN;
                    end
                    if (cnt_inc == asr_pkg::VOTE_SECOND_TICK) begin
                        n.votes[1] = RECEIVE_LINE_PIN_IN;
                    end
                    if (cnt_inc == asr_pkg::FULL_BIT_TICKS) begin
                        n.tick_cnt = asr_pkg::TICK_ZERO;
                        n.shift = {voted, r.shift[DATA_BITS-1:1]};
                        n.bit_cnt = r.bit_cnt + BW'(1);
                        if (r.bit_cnt == BIT_LAST) begin
                            n.state = asr_pkg::ASR_STOP;
                        end
                    end
                end
            end
            asr_pkg::ASR_STOP: begin
                if (tick) begin
                    n.tick_cnt = cnt_inc;
                    if (cnt_inc == asr_pkg::VOTE_FIRST_TICK) begin
                        n.votes[0] = RECEIVE_LINE_PIN_IN;
                    end
                    if (cnt_inc == asr_pkg::VOTE_SECOND_TICK) begin
                        n.votes[1] = RECEIVE_LINE_PIN_IN;
                    end
                    if (cnt_inc == asr_pkg::FULL_BIT_TICKS) begin
                        n.tick_cnt = asr_pkg::TICK_ZERO;
                        n.state = asr_pkg::ASR_IDLE;
                        // a read in this same cycle frees a slot before the check
                        if (r.count == CNT_FULL && !pop) begin
                            n.overrun = 1'b1;
                        end else begin
                            push = 1'b1;
                            n.mem[r.wr_ptr] = r.shift;
                            n.frame_error_status_mem[r.wr_ptr] = (voted != asr_pkg::STOP_LEVEL);
                            n.wr_ptr = ptr_next(r.wr_ptr);
                        end
                    end
                end
            end
        endcase

        // occupancy follows pushes and pops
        if (push && !pop) begin
            n.count = r.count + CNT_ONE;
        end else if (pop && !push) begin
            n.count = r.count - CNT_ONE;
        end

        // dropping receive enable aborts the character and clears overrun,
        // but leaves stored characters and their error status alone
        if (!CONTINUOUS_RECEIVE_ENABLE) begin
            n.state = asr_pkg::ASR_IDLE;
            n.overrun = 1'b0;
        end

        // port disable resets the unit, which also forces frame error clear
        if (!SERIAL_PORT_ENABLE) begin
            n.state = asr_pkg::ASR_IDLE;
            n.tick_cnt = asr_pkg::TICK_ZERO;
            n.bit_cnt = '0;
            n.rd_ptr = '0;
            n.wr_ptr = '0;
            n.count = '0;
            n.frame_error_status_mem = '0;
            n.overrun = 1'b0;
        end

        // status presented for the oldest unread character
        n.data_out = n.mem[n.rd_ptr];
        n.pending = SERIAL_PORT_ENABLE & CONTINUOUS_RECEIVE_ENABLE & (n.count != '0);
        n.frame_error_status_out = (n.count != '0) ? n.frame_error_status_mem[n.rd_ptr] : 1'b0;
        n.busy = (n.state != asr_pkg::ASR_IDLE);

        // pin steering: the port owns both pins while enabled
        n.rx_oe_n = SERIAL_PORT_ENABLE ? asr_pkg::PIN_RELEASED : RECEIVE_PIN_DIRECTION_BIT;
        n.rx_out = RECEIVE_PORT_LATCH;
        n.tx_oe_n = SERIAL_PORT_ENABLE ? ~asr_pkg::PIN_RELEASED : TRANSMIT_PIN_DIRECTION_BIT;
        n.tx_out = SERIAL_PORT_ENABLE ? TRANSMIT_SERIAL_DATA : TRANSMIT_PORT_LATCH;
    end

    // ==========================================================
    // state register; pins released and line taken as idle after reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            r <= '0;
            r.line_prev <= asr_pkg::LINE_IDLE;
            r.rx_oe_n <= asr_pkg::PIN_RELEASED;
            r.tx_oe_n <= asr_pkg::PIN_RELEASED;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign RECEIVE_HOLDING_DATA = r.data_out;
    assign RECEIVE_PENDING_FLAG = r.pending;
    assign FRAME_ERROR_STATUS = r.frame_error_status_out;
    assign OVERRUN_STATUS = r.overrun;
    assign RECEIVE_BUSY = r.busy;
    assign RECEIVE_LINE_PIN_OUT = r.rx_out;
    assign RECEIVE_LINE_PIN_OE_N = r.rx_oe_n;
    assign TRANSMIT_LINE_PIN_OUT = r.tx_out;
    assign TRANSMIT_LINE_PIN_OE_N = r.tx_oe_n;

endmodule

// file: pkg/asr_pkg.sv
// constants and types shared by the asynchronous serial receive path
package asr_pkg;

    // ==========================================================
    // clock and line rate
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int OVERSAMPLE = 16;
    // clocks per oversample tick, rounded down
    localparam int BAUD_DIV = CLK_HZ / (BAUD_RATE * OVERSAMPLE);

    // ==========================================================
    // bit timing in oversample ticks
    localparam int TICK_W = 5;
    localparam logic [TICK_W-1:0] HALF_BIT_TICKS = 5'h08;
    localparam logic [TICK_W-1:0] FULL_BIT_TICKS = 5'h10;
    localparam logic [TICK_W-1:0] VOTE_FIRST_TICK = 5'h0E;
    localparam logic [TICK_W-1:0] VOTE_SECOND_TICK = 5'h0F;
    localparam logic [TICK_W-1:0] TICK_ZERO = 5'h00;

    // ==========================================================
    // character format and buffering
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 2;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL = 1'b1;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic PIN_RELEASED = 1'b1;

    // ==========================================================
    // receiver sequence, gray coded along idle-start-data-stop
    typedef enum logic [1:0] {
        ASR_IDLE = 2'h0,
        ASR_START = 2'h1,
        ASR_DATA = 2'h3,
        ASR_STOP = 2'h2
    } asr_state_type;

endpackage

// file: rtl/asr_baud_tick.sv
// oversample tick generator running off the device clock
module asr_baud_tick #(
    parameter int DIV = asr_pkg::BAUD_DIV
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic enable,
    output logic tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } asr_baud_type;

    asr_baud_type r;
    asr_baud_type n;

    // ==========================================================
    // divider: one tick every DIV clocks, held at zero while disabled
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (!enable) begin
            n.cnt = '0;
        end else if (r.cnt == LAST) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + CW'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule

// file: verif/asr_receiver_asserts.sv
// concurrent checks on the ports of the asynchronous serial receive path
module asr_receiver_asserts #(
    parameter int DATA_BITS = 8,
    parameter int BAUD_DIV = 162
) (
    input logic CLK,
    input logic RST_N,
    input logic SERIAL_PORT_ENABLE,
    input logic CONTINUOUS_RECEIVE_ENABLE,
    input logic RECEIVE_LINE_PIN_IN,
    input logic TRANSMIT_SERIAL_DATA,
    input logic [DATA_BITS-1:0] RECEIVE_HOLDING_DATA,
    input logic RECEIVE_PENDING_FLAG,
    input logic FRAME_ERROR_STATUS,
    input logic OVERRUN_STATUS,
    input logic RECEIVE_BUSY,
    input logic RECEIVE_LINE_PIN_OE_N,
    input logic TRANSMIT_LINE_PIN_OUT,
    input logic TRANSMIT_LINE_PIN_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    // the first tick lands 1 to BAUD_DIV clocks after the start edge, so a
    // stretch that ends on tick n lasts (n-1)*BAUD_DIV+1 to n*BAUD_DIV clocks
    localparam int FRAME_LO = 151 * BAUD_DIV + 1;
    localparam int FRAME_HI = 152 * BAUD_DIV;
    localparam int ABORT_LO = 7 * BAUD_DIV + 1;
    localparam int ABORT_HI = 8 * BAUD_DIV;
    logic [15:0] busy_cnt_r;
    logic [15:0] busy_cnt_nxt;
    // ==========================================================
    // length of each busy stretch, in clocks
    always_comb busy_cnt_nxt = RECEIVE_BUSY ? busy_cnt_r + 16'h0001 : 16'h0000;
    always_ff @(posedge CLK) busy_cnt_r <= RST_N ? busy_cnt_nxt : 16'h0000;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ==========================================================
    // properties
    sequence s_line_fell;
        $past(RECEIVE_LINE_PIN_IN, 2) && !$past(RECEIVE_LINE_PIN_IN);
    endsequence
    sequence s_enabled;
        $past(RST_N) && $past(SERIAL_PORT_ENABLE) && $past(CONTINUOUS_RECEIVE_ENABLE);
    endsequence
    AST_RX_PIN_INPUT: assert property ($past(SERIAL_PORT_ENABLE) |-> RECEIVE_LINE_PIN_OE_N)
        else $error("receive pin driven while port enabled");
    AST_TX_PIN_SERIAL: assert property ($past(RST_N) && $past(SERIAL_PORT_ENABLE) |->
        !TRANSMIT_LINE_PIN_OE_N && TRANSMIT_LINE_PIN_OUT == $past(TRANSMIT_SERIAL_DATA))
        else $error("transmit pin not carrying serial data");
    AST_START_ON_FALL: assert property ($rose(RECEIVE_BUSY) |-> s_line_fell)
        else $error("character started without a falling edge");
    AST_BUSY_LENGTH: assert property ($fell(RECEIVE_BUSY) ##0 s_enabled |->
        busy_cnt_r inside {[ABORT_LO:ABORT_HI], [FRAME_LO:FRAME_HI]})
        else $error("busy stretch of wrong length");
    AST_OVERRUN_BLOCKS: assert property (OVERRUN_STATUS |=> !$rose(RECEIVE_BUSY))
        else $error("character started during overrun");
    AST_PENDING_ENABLED: assert property (RECEIVE_PENDING_FLAG |-> s_enabled)
        else $error("pending flag while receiver disabled");
    AST_FRAME_ERROR_STATUS_HAS_CHAR: assert property (FRAME_ERROR_STATUS ##0 s_enabled |-> RECEIVE_PENDING_FLAG)
        else $error("frame error with no unread character");
    AST_PORT_OFF_CLEARS: assert property ($past(RST_N) && !$past(SERIAL_PORT_ENABLE) |->
        !(FRAME_ERROR_STATUS || RECEIVE_PENDING_FLAG || OVERRUN_STATUS))
        else $error("status kept while port disabled");
endmodule
bind asr_receiver asr_receiver_asserts #(.DATA_BITS(DATA_BITS), .BAUD_DIV(BAUD_DIV)) u_asr_chk (
    .CLK(CLK),
    .RST_N(RST_N),
    .SERIAL_PORT_ENABLE(SERIAL_PORT_ENABLE),
    .CONTINUOUS_RECEIVE_ENABLE(CONTINUOUS_RECEIVE_ENABLE),
    .RECEIVE_LINE_PIN_IN(RECEIVE_LINE_PIN_IN),
    .TRANSMIT_SERIAL_DATA(TRANSMIT_SERIAL_DATA),
    .RECEIVE_HOLDING_DATA(RECEIVE_HOLDING_DATA),
    .RECEIVE_PENDING_FLAG(RECEIVE_PENDING_FLAG),
    .FRAME_ERROR_STATUS(FRAME_ERROR_STATUS),
    .OVERRUN_STATUS(OVERRUN_STATUS),
    .RECEIVE_BUSY(RECEIVE_BUSY),
    .RECEIVE_LINE_PIN_OE_N(RECEIVE_LINE_PIN_OE_N),
    .TRANSMIT_LINE_PIN_OUT(TRANSMIT_LINE_PIN_OUT),
    .TRANSMIT_LINE_PIN_OE_N(TRANSMIT_LINE_PIN_OE_N)
);

// file: verif/asr_tx_model.sv
// serial transmitter standing at the far end of the receive line
module asr_tx_model #(
    parameter int DIV = 2
) (
    input logic CLK,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16 * DIV;
    // the line idles high between frames
    initial line = 1'h1;
    // ==========================================================
    // frames and faults
    // flip spoils one tick near a data bit centre: one vote wrong, never the majority
    task automatic send(input logic [7:0] d, input logic stp, input logic [7:0] flip);
        logic [9:0] f;
        f = {stp, d, 1'h0};
        for (int b = 0; b < 10; b++) begin
            for (int c = 0; c < BIT; c++) begin
                line = (b > 0 && b < 9 && flip[b-1] && c >= 7 * DIV && c < 8 * DIV) ? ~f[b] : f[b];
                @(posedge CLK) #1;
            end
        end
        line = 1'h1;
        repeat (4) @(posedge CLK) #1;
    endtask
    // low pulse shorter than half a bit
    task automatic glitch(input int n);
        line = 1'h0;
        repeat (n) @(posedge CLK) #1;
        line = 1'h1;
        repeat (BIT) @(posedge CLK) #1;
    endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the asynchronous serial receive path
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // short divider keeps frames at 320 clocks
    localparam int DIV = 2;
    logic CLK = 1'h0, RST_N = 1'h0, SERIAL_PORT_ENABLE = 1'h0, CONTINUOUS_RECEIVE_ENABLE = 1'h0;
    logic RECEIVE_PIN_DIRECTION_BIT = 1'h0, RECEIVE_PORT_LATCH = 1'h1, TRANSMIT_PIN_DIRECTION_BIT = 1'h1;
    logic TRANSMIT_PORT_LATCH = 1'h1, TRANSMIT_SERIAL_DATA = 1'h0, RECEIVE_HOLDING_READ = 1'h0;
    logic RECEIVE_LINE_PIN_IN, RECEIVE_PENDING_FLAG, FRAME_ERROR_STATUS, OVERRUN_STATUS, RECEIVE_BUSY;
    logic RECEIVE_LINE_PIN_OUT, RECEIVE_LINE_PIN_OE_N, TRANSMIT_LINE_PIN_OUT, TRANSMIT_LINE_PIN_OE_N;
    logic [7:0] RECEIVE_HOLDING_DATA;
    int miscompares = 0, num_checks = 0;
    always #20 CLK = ~CLK;
    asr_receiver #(.BAUD_DIV(DIV)) dut (
        .CLK(CLK),
        .RST_N(RST_N),
        .SERIAL_PORT_ENABLE(SERIAL_PORT_ENABLE),
        .CONTINUOUS_RECEIVE_ENABLE(CONTINUOUS_RECEIVE_ENABLE),
        .RECEIVE_LINE_PIN_IN(RECEIVE_LINE_PIN_IN),
        .RECEIVE_PIN_DIRECTION_BIT(RECEIVE_PIN_DIRECTION_BIT),
        .RECEIVE_PORT_LATCH(RECEIVE_PORT_LATCH),
        .TRANSMIT_PIN_DIRECTION_BIT(TRANSMIT_PIN_DIRECTION_BIT),
        .TRANSMIT_PORT_LATCH(TRANSMIT_PORT_LATCH),
        .TRANSMIT_SERIAL_DATA(TRANSMIT_SERIAL_DATA),
        .RECEIVE_HOLDING_READ(RECEIVE_HOLDING_READ),
        .RECEIVE_HOLDING_DATA(RECEIVE_HOLDING_DATA),
        .RECEIVE_PENDING_FLAG(RECEIVE_PENDING_FLAG),
        .FRAME_ERROR_STATUS(FRAME_ERROR_STATUS),
        .OVERRUN_STATUS(OVERRUN_STATUS),
        .RECEIVE_BUSY(RECEIVE_BUSY),
        .RECEIVE_LINE_PIN_OUT(RECEIVE_LINE_PIN_OUT),
        .RECEIVE_LINE_PIN_OE_N(RECEIVE_LINE_PIN_OE_N),
        .TRANSMIT_LINE_PIN_OUT(TRANSMIT_LINE_PIN_OUT),
        .TRANSMIT_LINE_PIN_OE_N(TRANSMIT_LINE_PIN_OE_N)
    );
    // the line reaches the receiver as a plain digital level: analog select taken as cleared
    asr_tx_model #(.DIV(DIV)) txm (.CLK(CLK), .line(RECEIVE_LINE_PIN_IN));
    // ==========================================================
    // access tasks
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // data is only meaningful while a character is pending
    task automatic st(input logic [7:0] d, input logic p, input logic f);
        chk("pending", RECEIVE_PENDING_FLAG, p);
        chk("frame_error", FRAME_ERROR_STATUS, f);
        if (p) chk("data", RECEIVE_HOLDING_DATA, d);
    endtask
    // one-cycle strobe, then an idle edge so strobes never merge
    task automatic rd();
        RECEIVE_HOLDING_READ = 1'h1;
        @(posedge CLK) #1;
        RECEIVE_HOLDING_READ = 1'h0;
        @(posedge CLK) #1;
    endtask
    task automatic en(input logic spe, input logic cre);
        SERIAL_PORT_ENABLE = spe;
        CONTINUOUS_RECEIVE_ENABLE = cre;
        repeat (2) @(posedge CLK) #1;
    endtask
    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (2) @(posedge CLK);
        #1 RST_N = 1'h1;
        @(posedge CLK) #1;
        st(8'h00, 1'h0, 1'h0);
        chk("rx_oe_n", RECEIVE_LINE_PIN_OE_N, 8'h00);
        chk("rx_out", RECEIVE_LINE_PIN_OUT, 8'h01);
        chk("tx_oe_n", TRANSMIT_LINE_PIN_OE_N, 8'h01);
        en(1'h1, 1'h1);
        chk("rx_oe_n", RECEIVE_LINE_PIN_OE_N, 8'h01);
        chk("tx_oe_n", TRANSMIT_LINE_PIN_OE_N, 8'h00);
        chk("tx_out", TRANSMIT_LINE_PIN_OUT, 8'h00);
        // serial data must reach the pin; two edges keep the tick phase even
        TRANSMIT_SERIAL_DATA = 1'h1;
        en(1'h1, 1'h1);
        chk("tx_out", TRANSMIT_LINE_PIN_OUT, 8'h01);
        txm.glitch(4);
        st(8'h00, 1'h0, 1'h0);
        txm.send(8'hA3, 1'h1, 8'h5A);
        txm.send(8'h3C, 1'h0, 8'h00);
        st(8'hA3, 1'h1, 1'h0);
        rd();
        st(8'h3C, 1'h1, 1'h1);
        rd();
        st(8'h00, 1'h0, 1'h0);
        // third character finds the fifo full, the fourth must be ignored
        txm.send(8'hC5, 1'h0, 8'h00);
        txm.send(8'h96, 1'h1, 8'h00);
        txm.send(8'hE1, 1'h1, 8'h00);
        chk("overrun", OVERRUN_STATUS, 8'h01);
        txm.send(8'h7F, 1'h1, 8'h00);
        st(8'hC5, 1'h1, 1'h1);
        en(1'h1, 1'h0);
        st(8'h00, 1'h0, 1'h1);
        chk("overrun", OVERRUN_STATUS, 8'h00);
        en(1'h1, 1'h1);
        st(8'hC5, 1'h1, 1'h1);
        rd();
        st(8'h96, 1'h1, 1'h0);
        rd();
        st(8'h00, 1'h0, 1'h0);
        // a read on an empty fifo must not disturb the occupancy
        rd();
        st(8'h00, 1'h0, 1'h0);
        txm.send(8'h5A, 1'h0, 8'h00);
        st(8'h5A, 1'h1, 1'h1);
        en(1'h0, 1'h1);
        st(8'h00, 1'h0, 1'h0);
        en(1'h1, 1'h1);
        st(8'h00, 1'h0, 1'h0);
        final_report();
    end
    // about 2330 clocks are needed; a hang ends the run as a failure
    initial begin
        repeat (8000) @(posedge CLK);
        miscompares++;
        final_report();
    end
endmodule
